// ===== src/icd_consts.svh
// constants for the instruction cycle timing decoder
`ifndef ICD_CONSTS_SVH
`define ICD_CONSTS_SVH

// ----------------------------------------------------------------
// word and cycle timing
// ----------------------------------------------------------------
`define ICD_WORD_W      14
`define ICD_Q_PER_CYC   4
`define ICD_Q_LAST      2'(`ICD_Q_PER_CYC - 1)
`define ICD_Q_READ      2'h0
`define ICD_Q_WRITE     2'h2
`define ICD_CYC_ONE     2'h1
`define ICD_CYC_TWO     2'h2
`define ICD_NOP_WORD    14'h0000

// ----------------------------------------------------------------
// word fields
// ----------------------------------------------------------------
`define ICD_TOP_BYTE    2'h0
`define ICD_TOP_BIT     2'h1
`define ICD_TOP_JUMP    2'h2
`define ICD_IND_ADDR_HI 6'h00

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define ICD_OP_MISC     4'h0
`define ICD_OP_CLEAR    4'h1
`define ICD_OP_DEC_SKIP 4'hB
`define ICD_OP_INC_SKIP 4'hF
`define ICD_LO_RET_SUB  8'h08
`define ICD_LO_RET_INT  8'h09
`define ICD_LO_CALL_W   8'h0A
`define ICD_LO_BR_W     8'h0B
`define ICD_IMV_LOAD    5'h02
`define ICD_IMV_STORE   5'h03
`define ICD_OP_RET_LIT  4'h4
`define ICD_OP_REL_BR_A 4'h2
`define ICD_OP_REL_BR_B 4'h3
`define ICD_OP_IND_OFS  4'hF
`define ICD_OP_SHL      4'h5
`define ICD_OP_SHR      4'h6
`define ICD_OP_ASR      4'h7
`define ICD_OP_SUB_B    4'hB
`define ICD_OP_ADD_C    4'hD
`define ICD_OP_MOV_LIT  4'h0
`define ICD_OP_OR_LIT   4'h8
`define ICD_OP_AND_LIT  4'h9
`define ICD_OP_XOR_LIT  4'hA
`define ICD_OP_SUB_LIT  4'hC
`define ICD_OP_ADD_LIT  4'hE

`endif

// ===== src/icd_pkg.sv
// types for the instruction cycle timing decoder
package icd_pkg;
   typedef enum logic [1:0] {
      ICD_GRP_BYTE,
      ICD_GRP_BIT,
      ICD_GRP_LIT
   } icd_group_e;

   typedef enum logic [2:0] {
      ICD_CLS_PLAIN,
      ICD_CLS_CALL,
      ICD_CLS_RET,
      ICD_CLS_BRANCH,
      ICD_CLS_SKIP,
      ICD_CLS_IND_MOVE
   } icd_class_e;

   typedef enum logic [1:0] {
      ICD_PM_PRE_INC,
      ICD_PM_PRE_DEC,
      ICD_PM_POST_INC,
      ICD_PM_POST_DEC
   } icd_ptr_mode_e;
endpackage

// ===== src/icd_qphase.sv
// four-phase sequencer of one instruction cycle
`timescale 1ns/1ps
`include "icd_consts.svh"

module icd_qphase (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       ce,
   // phase
   output logic [1:0]      q_phase_r
);
   logic [1:0] q_phase_nxt;

   always_comb begin
      if (q_phase_r == `ICD_Q_LAST) begin
         q_phase_nxt = 2'h0;
      end else begin
         q_phase_nxt = q_phase_r + 2'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q_phase_r <= 2'h0;
      end else if (ce) begin
         q_phase_r <= q_phase_nxt;
      end
   end
endmodule

// ===== src/icd_decode.sv
// instruction decoder with instruction cycle timing
`timescale 1ns/1ps
`include "icd_consts.svh"

module icd_decode (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 arst_n,
   input  wire logic                 ce,
   // fetch path
   input  wire logic [13:0]          fetch_word,
   input  wire logic                 fetch_valid,
   // datapath status
   input  wire logic [1:0]           ptr_in_pm,
   input  wire logic                 skip_true,
   // phase
   output logic [1:0]                q_phase_r,
   // decoded instruction
   output icd_pkg::icd_group_e       grp_r,
   output icd_pkg::icd_class_e       cls_r,
   output logic [6:0]                file_addr_r,
   output logic [2:0]                bit_sel_r,
   output logic                      dest_file_r,
   output logic [10:0]               literal_r,
   output logic                      ptr_sel_r,
   output icd_pkg::icd_ptr_mode_e    ptr_mode_r,
   // timing and strobes
   output logic [1:0]                cycles_r,
   output logic                      exec_valid_r,
   output logic                      flush_r,
   output logic                      file_rd_r,
   output logic                      file_wr_r,
   output logic                      w_wr_r
);
   // ----------------------------------------------------------------
   // decode of the fetched word
   // ----------------------------------------------------------------
   logic [13:0]                w;
   logic [1:0]                 top;
   logic [3:0]                 op;
   icd_pkg::icd_group_e        dc_grp;
   icd_pkg::icd_class_e        dc_cls;
   icd_pkg::icd_ptr_mode_e     dc_mode;
   logic                       dc_rd;
   logic                       dc_wf;
   logic                       dc_ww;
   logic                       dc_ind;
   logic                       dc_ptr;
   logic                       dc_extra;
   logic [10:0]                dc_lit;
   logic [1:0]                 dc_cyc;

   icd_qphase u_qphase (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .ce        (ce),
      .q_phase_r (q_phase_r)
   );

   always_comb begin
      w       = fetch_valid ? fetch_word : `ICD_NOP_WORD;
      top     = w[13:12];
      op      = w[11:8];
      dc_grp  = icd_pkg::ICD_GRP_LIT;
      dc_cls  = icd_pkg::ICD_CLS_PLAIN;
      dc_mode = icd_pkg::ICD_PM_PRE_INC;
      dc_rd   = 1'b0;
      dc_wf   = 1'b0;
      dc_ww   = 1'b0;
      dc_ind  = 1'b0;
      dc_ptr  = 1'b0;
      dc_lit  = {3'h0, w[7:0]};
      case (top)
         `ICD_TOP_BYTE: begin
            dc_grp = icd_pkg::ICD_GRP_BYTE;
            dc_rd  = 1'b1;
            dc_wf  = w[7];
            dc_ww  = !w[7];
            if (op == `ICD_OP_MISC && !w[7]) begin
               dc_grp = icd_pkg::ICD_GRP_LIT;
               dc_rd  = 1'b0;
               dc_ww  = 1'b0;
               case (w[7:0])
                  `ICD_LO_RET_SUB, `ICD_LO_RET_INT: begin
                     dc_cls = icd_pkg::ICD_CLS_RET;
                  end
                  `ICD_LO_CALL_W: begin
                     dc_cls = icd_pkg::ICD_CLS_CALL;
                  end
                  `ICD_LO_BR_W: begin
                     dc_cls = icd_pkg::ICD_CLS_BRANCH;
                  end
                  default: begin
                     if (w[7:3] == `ICD_IMV_LOAD ||
                         w[7:3] == `ICD_IMV_STORE) begin
                        dc_cls  = icd_pkg::ICD_CLS_IND_MOVE;
                        dc_ind  = 1'b1;
                        dc_ptr  = w[2];
                        dc_mode = icd_pkg::icd_ptr_mode_e'(w[1:0]);
                        dc_rd   = 1'b1;
                        dc_wf   = w[3];
                        dc_ww   = !w[3];
                     end
                  end
               endcase
            end else if (op == `ICD_OP_CLEAR) begin
               // clearing W leaves the address field unused
               dc_rd = w[7];
            end else if (op == `ICD_OP_DEC_SKIP ||
                         op == `ICD_OP_INC_SKIP) begin
               dc_cls = icd_pkg::ICD_CLS_SKIP;
            end
         end
         `ICD_TOP_BIT: begin
            dc_grp = icd_pkg::ICD_GRP_BIT;
            dc_rd  = 1'b1;
            if (op[3]) begin
               dc_cls = icd_pkg::ICD_CLS_SKIP;
            end else begin
               dc_wf  = 1'b1;
            end
         end
         `ICD_TOP_JUMP: begin
            dc_lit = w[10:0];
            if (!w[11]) begin
               dc_cls = icd_pkg::ICD_CLS_CALL;
            end else begin
               dc_cls = icd_pkg::ICD_CLS_BRANCH;
            end
         end
         default: begin
            case (op)
               `ICD_OP_RET_LIT: begin
                  dc_cls = icd_pkg::ICD_CLS_RET;
                  dc_ww  = 1'b1;
               end
               `ICD_OP_REL_BR_A, `ICD_OP_REL_BR_B: begin
                  dc_cls = icd_pkg::ICD_CLS_BRANCH;
                  dc_lit = {2'h0, w[8:0]};
               end
               `ICD_OP_IND_OFS: begin
                  dc_cls = icd_pkg::ICD_CLS_IND_MOVE;
                  dc_ind = 1'b1;
                  dc_ptr = w[6];
                  dc_rd  = 1'b1;
                  dc_wf  = w[7];
                  dc_ww  = !w[7];
                  dc_lit = {5'h0, w[5:0]};
               end
               `ICD_OP_SHL, `ICD_OP_SHR, `ICD_OP_ASR,
               `ICD_OP_SUB_B, `ICD_OP_ADD_C: begin
                  dc_grp = icd_pkg::ICD_GRP_BYTE;
                  dc_rd  = 1'b1;
                  dc_wf  = w[7];
                  dc_ww  = !w[7];
               end
               `ICD_OP_MOV_LIT, `ICD_OP_OR_LIT, `ICD_OP_AND_LIT,
               `ICD_OP_XOR_LIT, `ICD_OP_SUB_LIT, `ICD_OP_ADD_LIT: begin
                  dc_ww  = 1'b1;
               end
               default: begin
                  dc_ww  = 1'b0;
               end
            endcase
         end
      endcase
      // the indirect access registers sit at the bottom of every bank;
      // only a word that really reads its file operand counts, so the
      // free address bits of clear-w never cost an extra cycle
      if (dc_grp != icd_pkg::ICD_GRP_LIT && dc_rd &&
          w[6:1] == `ICD_IND_ADDR_HI) begin
         dc_ind = 1'b1;
         dc_ptr = w[0];
      end
      dc_extra = dc_ind && ptr_in_pm[dc_ptr];
      if (dc_cls == icd_pkg::ICD_CLS_CALL ||
          dc_cls == icd_pkg::ICD_CLS_RET ||
          dc_cls == icd_pkg::ICD_CLS_BRANCH) begin
         dc_cyc = `ICD_CYC_TWO;
      end else begin
         dc_cyc = `ICD_CYC_ONE;
      end
      dc_cyc = dc_cyc + {1'b0, dc_extra};
   end

   // ----------------------------------------------------------------
   // cycle sequencing
   // ----------------------------------------------------------------
   logic [1:0]                 rem_r;
   logic [1:0]                 rem_nxt;
   logic                       skip_arm_r;
   logic                       skip_arm_nxt;
   logic                       rd_f_r;
   logic                       rd_f_nxt;
   logic                       wf_r;
   logic                       wf_nxt;
   logic                       ww_r;
   logic                       ww_nxt;
   logic                       skip_hit;
   icd_pkg::icd_group_e        grp_nxt;
   icd_pkg::icd_class_e        cls_nxt;
   icd_pkg::icd_ptr_mode_e     ptr_mode_nxt;
   logic [6:0]                 file_addr_nxt;
   logic [2:0]                 bit_sel_nxt;
   logic                       dest_file_nxt;
   logic [10:0]                literal_nxt;
   logic                       ptr_sel_nxt;
   logic [1:0]                 cycles_nxt;
   logic                       exec_valid_nxt;
   logic                       flush_nxt;
   logic                       file_rd_nxt;
   logic                       file_wr_nxt;
   logic                       w_wr_nxt;

   always_comb begin
      skip_hit       = skip_arm_r && rem_r == 2'h0 && skip_true;
      rem_nxt        = rem_r;
      skip_arm_nxt   = skip_arm_r;
      rd_f_nxt       = rd_f_r;
      wf_nxt         = wf_r;
      ww_nxt         = ww_r;
      grp_nxt        = grp_r;
      cls_nxt        = cls_r;
      ptr_mode_nxt   = ptr_mode_r;
      file_addr_nxt  = file_addr_r;
      bit_sel_nxt    = bit_sel_r;
      dest_file_nxt  = dest_file_r;
      literal_nxt    = literal_r;
      ptr_sel_nxt    = ptr_sel_r;
      cycles_nxt     = cycles_r;
      exec_valid_nxt = exec_valid_r;
      flush_nxt      = flush_r;
      file_rd_nxt    = 1'b0;
      file_wr_nxt    = 1'b0;
      w_wr_nxt       = 1'b0;
      // read in the second phase, write back in the fourth
      if (exec_valid_r && q_phase_r == `ICD_Q_READ) begin
         file_rd_nxt = rd_f_r;
      end
      if (exec_valid_r && q_phase_r == `ICD_Q_WRITE) begin
         file_wr_nxt = wf_r;
         w_wr_nxt    = ww_r;
      end
      if (q_phase_r == `ICD_Q_LAST) begin
         if (rem_r != 2'h0 || skip_hit) begin
            // prefetched word is dropped, nothing executes
            flush_nxt      = 1'b1;
            exec_valid_nxt = 1'b0;
            if (skip_hit) begin
               skip_arm_nxt = 1'b0;
               cycles_nxt   = cycles_r + 2'h1;
            end else begin
               rem_nxt      = rem_r - 2'h1;
            end
         end else begin
            flush_nxt      = 1'b0;
            exec_valid_nxt = fetch_valid;
            grp_nxt        = dc_grp;
            cls_nxt        = dc_cls;
            ptr_mode_nxt   = dc_mode;
            file_addr_nxt  = w[6:0];
            bit_sel_nxt    = w[9:7];
            dest_file_nxt  = (dc_grp == icd_pkg::ICD_GRP_BYTE) ?
                             w[7] : dc_wf;
            literal_nxt    = dc_lit;
            ptr_sel_nxt    = dc_ptr;
            cycles_nxt     = dc_cyc;
            rem_nxt        = dc_cyc - 2'h1;
            skip_arm_nxt   = dc_cls == icd_pkg::ICD_CLS_SKIP;
            rd_f_nxt       = dc_rd;
            wf_nxt         = dc_wf;
            ww_nxt         = dc_ww;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rem_r        <= 2'h0;
         skip_arm_r   <= 1'b0;
         rd_f_r       <= 1'b0;
         wf_r         <= 1'b0;
         ww_r         <= 1'b0;
         grp_r        <= icd_pkg::ICD_GRP_LIT;
         cls_r        <= icd_pkg::ICD_CLS_PLAIN;
         ptr_mode_r   <= icd_pkg::ICD_PM_PRE_INC;
         file_addr_r  <= 7'h00;
         bit_sel_r    <= 3'h0;
         dest_file_r  <= 1'b0;
         literal_r    <= 11'h000;
         ptr_sel_r    <= 1'b0;
         cycles_r     <= `ICD_CYC_ONE;
         exec_valid_r <= 1'b0;
         flush_r      <= 1'b0;
         file_rd_r    <= 1'b0;
         file_wr_r    <= 1'b0;
         w_wr_r       <= 1'b0;
      end else if (ce) begin
         rem_r        <= rem_nxt;
         skip_arm_r   <= skip_arm_nxt;
         rd_f_r       <= rd_f_nxt;
         wf_r         <= wf_nxt;
         ww_r         <= ww_nxt;
         grp_r        <= grp_nxt;
         cls_r        <= cls_nxt;
         ptr_mode_r   <= ptr_mode_nxt;
         file_addr_r  <= file_addr_nxt;
         bit_sel_r    <= bit_sel_nxt;
         dest_file_r  <= dest_file_nxt;
         literal_r    <= literal_nxt;
         ptr_sel_r    <= ptr_sel_nxt;
         cycles_r     <= cycles_nxt;
         exec_valid_r <= exec_valid_nxt;
         flush_r      <= flush_nxt;
         file_rd_r    <= file_rd_nxt;
         file_wr_r    <= file_wr_nxt;
         w_wr_r       <= w_wr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic rd_seen_r;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rd_seen_r <= 1'b0;
      end else if (file_rd_r) begin
         rd_seen_r <= 1'b1;
      end else if (ce && q_phase_r == `ICD_Q_LAST) begin
         rd_seen_r <= 1'b0;
      end
   end

   sequence s_skip_hit;
      ce && q_phase_r == `ICD_Q_LAST && skip_hit;
   endsequence
   sequence s_skip_miss;
      ce && q_phase_r == `ICD_Q_LAST && skip_arm_r &&
      rem_r == 2'h0 && !skip_true;
   endsequence

   a_phase_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && q_phase_r == 2'h3 |=> q_phase_r == 2'h0)
      else $error("phase did not wrap after four clocks");
   a_single_cycle: assert property (@(posedge clk_sys) disable iff (!arst_n)
      exec_valid_r && cls_r == icd_pkg::ICD_CLS_PLAIN && rem_r == 2'h0
      |-> cycles_r == 2'h1)
      else $error("plain instruction not single cycle");
   a_call_cycles: assert property (@(posedge clk_sys) disable iff (!arst_n)
      exec_valid_r && cls_r == icd_pkg::ICD_CLS_CALL |-> cycles_r == 2'h2)
      else $error("call not two cycles");
   a_ret_cycles: assert property (@(posedge clk_sys) disable iff (!arst_n)
      exec_valid_r && cls_r == icd_pkg::ICD_CLS_RET |-> cycles_r == 2'h2)
      else $error("return not two cycles");
   a_branch_cycles: assert property (@(posedge clk_sys) disable iff (!arst_n)
      exec_valid_r && cls_r == icd_pkg::ICD_CLS_BRANCH |-> rem_r == 2'h1)
      else $error("branch not followed by a flush cycle");
   a_ind_extra: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && q_phase_r == 2'h3 && rem_r == 2'h0 && !skip_hit && fetch_valid
      && dc_extra && dc_cls == icd_pkg::ICD_CLS_PLAIN
      |=> cycles_r == 2'h2 && exec_valid_r)
      else $error("indirect program memory access lacks extra cycle");
   a_rmw_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
      file_wr_r |-> rd_seen_r)
      else $error("file write without prior read");
   a_dest_steer: assert property (@(posedge clk_sys) disable iff (!arst_n)
      grp_r == icd_pkg::ICD_GRP_BYTE && (w_wr_r || file_wr_r)
      |-> (file_wr_r == dest_file_r) && (w_wr_r != dest_file_r))
      else $error("destination select misrouted");
   a_flush_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
      flush_r |-> !exec_valid_r && !file_rd_r && !file_wr_r && !w_wr_r)
      else $error("flush cycle performed an access");
   a_skip_taken: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_skip_hit |=> flush_r && cycles_r == $past(cycles_r) + 2'h1)
      else $error("taken skip did not add a cycle");
   a_skip_missed: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_skip_miss |=> !flush_r)
      else $error("untaken skip added a cycle");
endmodule

// ===== verif/icd_fetch_model.sv
// program memory fetch path model facing the decoder
`timescale 1ns/1ps

module icd_fetch_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // decoder phase
   input  wire logic [1:0]  q_phase_r,
   // word chosen by the bench
   input  wire logic [13:0] word_in,
   input  wire logic        valid_in,
   // fetch path
   output logic [13:0]      fetch_word,
   output logic             fetch_valid
);
   // ----
   // presentation
   // ----
   // the word is shown only in the phase before the load edge; at other
   // times the bus carries the inverse of its last value, so a decoder
   // that samples at the wrong edge picks up garbage, not a stale word
   initial begin
      fetch_word  = 14'h3FFF;
      fetch_valid = 1'b0;
   end

   always @(posedge clk_sys) begin
      #1;
      if (arst_n && q_phase_r == 2'h3) begin
         fetch_word  = word_in;
         fetch_valid = valid_in;
      end else begin
         fetch_word  = ~fetch_word;
         fetch_valid = 1'b0;
      end
   end
endmodule

// ===== verif/test_instruction_cycle_timing_decode.sv
// self-checking bench for the instruction cycle timing decoder
`timescale 1ns/1ps

module test_instruction_cycle_timing_decode;
   // ----
   // signals
   // ----
   logic                   clk_sys;
   logic                   arst_n;
   logic                   ce;
   logic [13:0]            word_in;
   logic                   valid_in;
   logic [13:0]            fetch_word;
   logic                   fetch_valid;
   logic [1:0]             ptr_in_pm;
   logic                   skip_true;
   logic [1:0]             q_phase_r;
   icd_pkg::icd_group_e    grp_r;
   icd_pkg::icd_class_e    cls_r;
   logic [6:0]             file_addr_r;
   logic [2:0]             bit_sel_r;
   logic                   dest_file_r;
   logic [10:0]            literal_r;
   logic                   ptr_sel_r;
   icd_pkg::icd_ptr_mode_e ptr_mode_r;
   logic [1:0]             cycles_r;
   logic                   exec_valid_r;
   logic                   flush_r;
   logic                   file_rd_r;
   logic                   file_wr_r;
   logic                   w_wr_r;
   logic [15:0]            n_clk, n_rd, n_wr, n_ww, n_fl;
   int                     n_fail;
   int                     num_checks;

   icd_decode dut (
      .clk_sys, .arst_n, .ce, .fetch_word, .fetch_valid, .ptr_in_pm,
      .skip_true, .q_phase_r, .grp_r, .cls_r, .file_addr_r, .bit_sel_r,
      .dest_file_r, .literal_r, .ptr_sel_r, .ptr_mode_r, .cycles_r,
      .exec_valid_r, .flush_r, .file_rd_r, .file_wr_r, .w_wr_r
   );

   icd_fetch_model fetch (
      .clk_sys, .arst_n, .q_phase_r, .word_in, .valid_in, .fetch_word,
      .fetch_valid
   );

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // ----
   // shared tasks
   // ----
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic hang;
      n_fail++;
      $display("Error at %0t: wait ran out", $time);
      complete_run();
   endtask

   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask

   // a load is the edge that enters phase 0 without a forced no-op
   task automatic load(input logic [13:0] w, input logic v,
                       input logic [1:0] pm, input logic sk);
      int i;
      word_in = w;
      valid_in = v;
      ptr_in_pm = pm;
      skip_true = sk;
      for (i = 0; i < 64; i++) begin
         step();
         if (q_phase_r === 2'h0 && flush_r === 1'b0) return;
      end
      hang();
   endtask

   // counts clocks and strobes up to the next load, which takes a nop;
   // skip_true is left alone since a skip samples it late
   task automatic measure;
      int i;
      word_in = 14'h0000;
      valid_in = 1'b1;
      ptr_in_pm = 2'h0;
      {n_clk, n_rd, n_wr, n_ww, n_fl} = '0;
      for (i = 0; i < 64; i++) begin
         step();
         n_clk++;
         n_rd += file_rd_r;
         n_wr += file_wr_r;
         n_ww += w_wr_r;
         n_fl += flush_r;
         if (q_phase_r === 2'h0 && flush_r === 1'b0) return;
      end
      hang();
   endtask

   // ----
   // scenarios
   // ----
   task automatic t_groups;
      load(14'h07A0, 1'b1, 2'h0, 1'b0);
      check(grp_r, icd_pkg::ICD_GRP_BYTE);
      check(exec_valid_r, 1'b1);
      check({dest_file_r, file_addr_r}, 8'hA0);
      measure();
      check(n_clk, 16'h0004);
      check({n_rd[3:0], n_wr[3:0], n_ww[3:0]}, 12'h110);
      load(14'h1392, 1'b1, 2'h0, 1'b0);
      check(grp_r, icd_pkg::ICD_GRP_BIT);
      check({bit_sel_r, file_addr_r}, 10'h392);
      measure();
      check(n_clk, 16'h0004);
      load(14'h3055, 1'b1, 2'h0, 1'b0);
      check(grp_r, icd_pkg::ICD_GRP_LIT);
      check(literal_r, 11'h055);
      measure();
      check(n_clk, 16'h0004);
   endtask

   task automatic t_flow;
      logic [13:0] fw [8] = '{14'h2123, 14'h000A, 14'h0008, 14'h0009,
                              14'h3455, 14'h2ABC, 14'h33AA, 14'h000B};
      logic [10:0] fk [8] = '{11'h123, 11'h00A, 11'h008, 11'h009,
                              11'h055, 11'h2BC, 11'h1AA, 11'h00B};
      icd_pkg::icd_class_e fc;
      for (int i = 0; i < 8; i++) begin
         fc = (i < 2) ? icd_pkg::ICD_CLS_CALL :
              (i < 5) ? icd_pkg::ICD_CLS_RET : icd_pkg::ICD_CLS_BRANCH;
         load(fw[i], 1'b1, 2'h0, 1'b0);
         check(cls_r, fc);
         check(cycles_r, 2'h2);
         check(literal_r, fk[i]);
         measure();
         check(n_clk, 16'h0008);
         check(n_fl, 16'h0004);
         check({n_rd[3:0], n_wr[3:0]}, 8'h00);
      end
   endtask

   task automatic t_skip;
      logic [13:0] sw [4] = '{14'h1C12, 14'h1812, 14'h0BA0, 14'h0F20};
      for (int i = 0; i < 4; i++) begin
         for (int s = 0; s < 2; s++) begin
            load(sw[i], 1'b1, 2'h0, s[0]);
            check(cls_r, icd_pkg::ICD_CLS_SKIP);
            measure();
            check(n_clk, 16'(4 + 4 * s));
            check(n_fl, 16'(4 * s));
            check({n_rd[3:0], n_wr[3:0], n_ww[3:0]},
                  {4'h1, 3'h0, 1'(i == 2), 3'h0, 1'(i == 3)});
         end
      end
   endtask

   task automatic t_indirect;
      load(14'h0781, 1'b1, 2'h2, 1'b0);
      check(cycles_r, 2'h2);
      measure();
      check(n_clk, 16'h0008);
      check(n_fl, 16'h0004);
      load(14'h0781, 1'b1, 2'h1, 1'b0);
      measure();
      check(n_clk, 16'h0004);
      load(14'h0010, 1'b1, 2'h2, 1'b0);
      check(ptr_sel_r, 1'b0);
      measure();
      check(n_clk, 16'h0004);
      for (int m = 0; m < 4; m++) begin
         load(14'h0014 | 14'(m), 1'b1, 2'h2, 1'b0);
         check(cls_r, icd_pkg::ICD_CLS_IND_MOVE);
         check({ptr_sel_r, ptr_mode_r}, {1'b1, 2'(m)});
         measure();
         check(n_clk, 16'h0008);
      end
   endtask

   // clear-w with its free bits at both extremes, pointers in program
   // memory so a wrong indirect reading would cost a cycle
   task automatic t_dontcare;
      for (int i = 0; i < 2; i++) begin
         load(i ? 14'h017F : 14'h0100, 1'b1, 2'h3, 1'b0);
         check(grp_r, icd_pkg::ICD_GRP_BYTE);
         measure();
         check({n_clk[3:0], n_rd[3:0], n_wr[3:0], n_ww[3:0]},
               16'h4001);
      end
   endtask

   task automatic t_rmw;
      load(14'h077F, 1'b1, 2'h0, 1'b0);
      check({dest_file_r, file_addr_r}, 8'h7F);
      measure();
      check({n_rd[3:0], n_wr[3:0], n_ww[3:0]}, 12'h101);
      load(14'h00A5, 1'b1, 2'h0, 1'b0);
      measure();
      check({n_rd[3:0], n_wr[3:0], n_ww[3:0]}, 12'h110);
   endtask

   task automatic t_hold;
      load(14'h07A0, 1'b0, 2'h0, 1'b0);
      check(exec_valid_r, 1'b0);
      measure();
      check({n_rd[3:0], n_wr[3:0], n_ww[3:0]}, 12'h000);
      load(14'h07A0, 1'b1, 2'h0, 1'b0);
      ce = 1'b0;
      repeat (5) step();
      check(q_phase_r, 2'h0);
      ce = 1'b1;
      measure();
      check(n_clk, 16'h0004);
      check(n_rd, 16'h0001);
   endtask

   initial begin
      arst_n = 1'b0;
      ce = 1'b1;
      word_in = 14'h0000;
      valid_in = 1'b0;
      ptr_in_pm = 2'h0;
      skip_true = 1'b0;
      n_fail = 0;
      num_checks = 0;
      repeat (3) @(posedge clk_sys);
      #1;
      check(cycles_r, 2'h1);
      check(q_phase_r, 2'h0);
      arst_n = 1'b1;
      t_groups();
      t_flow();
      t_skip();
      t_indirect();
      t_dontcare();
      t_rmw();
      t_hold();
      complete_run();
   end
endmodule
